/* File: common/absel_map.svh */
`ifndef ABSEL_MAP_SVH
`define ABSEL_MAP_SVH

// register byte offsets on the register port
`define ABSEL_CSW0_OFS 16'hB000
`define ABSEL_CSW1_OFS 16'hB004
`define ABSEL_CSW2_OFS 16'hB008
`define ABSEL_CSW3_OFS 16'hB00C
`define ABSEL_RX_ACK_OFS 16'hB030
`define ABSEL_TX_ACK_OFS 16'hB038
`define ABSEL_CTRL_OFS 16'hC000

// chip_select_window fields
`define ABSEL_CSW_BASE_MSB 21
`define ABSEL_CSW_BASE_LSB 17
`define ABSEL_CSW_ACT_MSB 14
`define ABSEL_CSW_ACT_LSB 12
`define ABSEL_CSW_RES_MSB 10
`define ABSEL_CSW_RES_LSB 9
`define ABSEL_CSW_SIZE_MSB 5
`define ABSEL_CSW_SIZE_LSB 4
`define ABSEL_CSW_EN_BIT 0

// ack_pulse_timing fields
`define ABSEL_ACK_LOW_MSB 6
`define ABSEL_ACK_LOW_LSB 4
`define ABSEL_ACK_HIGH_MSB 1
`define ABSEL_ACK_HIGH_LSB 0

// aux_bus_control fields and reset values
`define ABSEL_CTRL_CLKDIS_BIT 1
`define ABSEL_CTRL_RST_BIT 0
`define ABSEL_CTRL_CLKDIS_RST 1'h0
`define ABSEL_CTRL_RST_RST 1'h0

// host address bits compared against the window base
`define ABSEL_HADDR_WIN_MSB 17
`define ABSEL_HADDR_WIN_LSB 13

// timing counts in local bus clocks: field value plus base
`define ABSEL_ACT_BASE 4'h3
`define ABSEL_RES_BASE 4'h2
`define ABSEL_ACK_LOW_BASE 4'h2
`define ABSEL_ACK_HIGH_BASE 4'h1

`endif

/* File: common/absel_pkg.sv */
package absel_pkg;

  typedef enum logic [1:0] {
    ACC_IDLE,
    ACC_ACTIVE,
    ACC_RESTORE
  } absel_acc_e;

  typedef enum logic [1:0] {
    ACK_IDLE,
    ACK_LOW,
    ACK_HIGH
  } absel_ack_e;

  typedef struct packed {
    logic [3:0][4:0] base;
    logic [3:0][2:0] act;
    logic [3:0][1:0] res;
    logic [3:0][1:0] size;
    logic [3:0] en;
    logic [2:0] rx_low;
    logic [1:0] rx_high;
    logic [2:0] tx_low;
    logic [1:0] tx_high;
    logic clk_dis;
    logic sw_rst;
    logic aux_rst;
    logic [31:0] rdata;
    logic rvalid;
    absel_acc_e acc_st;
    logic [3:0] acc_cnt;
    logic [3:0] cs_n;
    logic acc_busy;
    logic acc_done;
    logic acc_miss;
    absel_ack_e ack_st;
    logic [3:0] ack_cnt;
    logic ack_n;
    logic ack_busy;
    logic ack_done;
    logic ack_high_tx;
    logic clk_en;
  } absel_state_s;

endpackage

/* File: rtl/absel_top.sv */
`timescale 1ns/1ps
`include "absel_map.svh"

// How it works
// - each window base sits on any 8KB boundary within the 256KB space.
// - bits 5-4 pick window size 8K, 16K, 32K or 64K.
// - base bits 21-17 match host address 17-13, fewer as size grows.
// - chip select held low for 3 plus field 14-12 clocks.
// - chip select held high 2 plus field 10-9 clocks after each access.
// - bit 0 enables a window; disabled windows never assert.
// - only byte devices; device width bits 2-1 always read 00.
// - four window registers at B000, B004, B008 and B00C.
// - dma ack low for 2 plus field 6-4 clocks.
// - dma ack high for 1 plus field 1-0 clocks.
// - receive timing at B030, transmit timing at B038.
// - control bit 1 disables the aux clock driver; enabled after reset.
// - control bit 0 drives the aux bus reset output.
// - aux bus reset also active while chip reset is active.
// - no parity generated or checked, and no parity control bit.
// - reset clears window enables and reserved bits.
// - only byte accesses from 4-byte aligned host addresses.
module absel_top (
  input wire logic clock_in, // local bus clock
  input wire logic resetn_in, // chip reset, sync, active low
  input wire logic reg_wr_in, // register write strobe
  input wire logic reg_rd_in, // register read strobe
  input wire logic [15:0] reg_addr_in, // register byte offset
  input wire logic [31:0] reg_wdata_in, // register write data
  output logic [31:0] reg_rdata_out, // register read data
  output logic reg_rvalid_out, // read data valid pulse
  input wire logic acc_req_in, // aux bus access request
  input wire logic [17:0] acc_addr_in, // host address of access
  output logic acc_busy_out, // access in progress
  output logic acc_done_out, // access finished pulse
  output logic acc_miss_out, // access refused pulse
  output logic [3:0] cs_n_out, // chip selects, active low
  input wire logic ack_req_in, // dma ack cycle request
  input wire logic ack_is_tx_in, // 1 = transmit channel timing
  output logic ack_busy_out, // ack cycle in progress
  output logic ack_done_out, // ack cycle finished pulse
  output logic dma_ack_n_out, // dma acknowledge, active low
  output logic aux_clk_enable_out, // aux clock driver enable
  output logic aux_reset_out // aux bus reset, active high
);

  absel_pkg::absel_state_s r;
  absel_pkg::absel_state_s n;

  logic hit;
  logic [1:0] hit_idx;
  logic [3:0] win_hit;
  logic [1:0] cs_idx;
  logic [1:0] wsel;

  // one comparator per window; the mask drops base bits a big window covers
  for (genvar g = 0; g < 4; g++) begin : g_win
    logic [4:0] win_mask;
    assign win_mask = 5'h1F << r.size[g];
    assign win_hit[g] = r.en[g] &&
      (((acc_addr_in[`ABSEL_HADDR_WIN_MSB:`ABSEL_HADDR_WIN_LSB] ^
         r.base[g]) & win_mask) == 5'h00);
  end

  // lowest index wins if software lets windows overlap
  always_comb begin
    hit = |win_hit;
    hit_idx = 2'h0;
    for (int i = 3; i >= 0; i--) begin
      if (win_hit[i]) begin
        hit_idx = 2'(i);
      end
    end
  end

  // window now strobed; its restore field sets the following gap
  always_comb begin
    cs_idx = 2'h0;
    for (int j = 0; j < 4; j++) begin
      if (!r.cs_n[j]) begin
        cs_idx = 2'(j);
      end
    end
  end

  always_comb begin
    n = r;
    wsel = reg_addr_in[3:2];
    n.acc_done = 1'b0;
    n.acc_miss = 1'b0;
    n.ack_done = 1'b0;
    n.rvalid = 1'b0;

    // register writes; reserved bits are simply not stored
    if (reg_wr_in) begin
      if (reg_addr_in == `ABSEL_CSW0_OFS || reg_addr_in == `ABSEL_CSW1_OFS ||
          reg_addr_in == `ABSEL_CSW2_OFS ||
          reg_addr_in == `ABSEL_CSW3_OFS) begin
        n.base[wsel] =
          reg_wdata_in[`ABSEL_CSW_BASE_MSB:`ABSEL_CSW_BASE_LSB];
        n.act[wsel] = reg_wdata_in[`ABSEL_CSW_ACT_MSB:`ABSEL_CSW_ACT_LSB];
        n.res[wsel] = reg_wdata_in[`ABSEL_CSW_RES_MSB:`ABSEL_CSW_RES_LSB];
        n.size[wsel] =
          reg_wdata_in[`ABSEL_CSW_SIZE_MSB:`ABSEL_CSW_SIZE_LSB];
        n.en[wsel] = reg_wdata_in[`ABSEL_CSW_EN_BIT];
      end else if (reg_addr_in == `ABSEL_RX_ACK_OFS) begin
        n.rx_low = reg_wdata_in[`ABSEL_ACK_LOW_MSB:`ABSEL_ACK_LOW_LSB];
        n.rx_high = reg_wdata_in[`ABSEL_ACK_HIGH_MSB:`ABSEL_ACK_HIGH_LSB];
      end else if (reg_addr_in == `ABSEL_TX_ACK_OFS) begin
        n.tx_low = reg_wdata_in[`ABSEL_ACK_LOW_MSB:`ABSEL_ACK_LOW_LSB];
        n.tx_high = reg_wdata_in[`ABSEL_ACK_HIGH_MSB:`ABSEL_ACK_HIGH_LSB];
      end else if (reg_addr_in == `ABSEL_CTRL_OFS) begin
        n.clk_dis = reg_wdata_in[`ABSEL_CTRL_CLKDIS_BIT];
        n.sw_rst = reg_wdata_in[`ABSEL_CTRL_RST_BIT];
      end
    end

    // register reads; unmapped offsets return zero
    if (reg_rd_in) begin
      n.rvalid = 1'b1;
      if (reg_addr_in == `ABSEL_CSW0_OFS || reg_addr_in == `ABSEL_CSW1_OFS ||
          reg_addr_in == `ABSEL_CSW2_OFS ||
          reg_addr_in == `ABSEL_CSW3_OFS) begin
        // device width bits stay 00: byte devices only
        n.rdata = {10'h0, r.base[wsel], 2'h0, r.act[wsel], 1'b0,
                   r.res[wsel], 3'h0, r.size[wsel], 3'h0,
                   r.en[wsel]};
      end else if (reg_addr_in == `ABSEL_RX_ACK_OFS) begin
        n.rdata = {25'h0, r.rx_low, 2'h0, r.rx_high};
      end else if (reg_addr_in == `ABSEL_TX_ACK_OFS) begin
        n.rdata = {25'h0, r.tx_low, 2'h0, r.tx_high};
      end else if (reg_addr_in == `ABSEL_CTRL_OFS) begin
        // no parity disable bit exists here
        n.rdata = {30'h0, r.clk_dis, r.sw_rst};
      end else begin
        n.rdata = 32'h00000000;
      end
    end

    // chip select sequencer
    case (r.acc_st)
      absel_pkg::ACC_IDLE: begin
        if (acc_req_in) begin
          // misaligned or unmatched address: no strobe at all
          if (acc_addr_in[1:0] != 2'h0 || !hit) begin
            n.acc_miss = 1'b1;
          end else begin
            n.acc_st = absel_pkg::ACC_ACTIVE;
            n.acc_busy = 1'b1;
            n.cs_n = ~(4'h1 << hit_idx);
            n.acc_cnt = `ABSEL_ACT_BASE + {1'b0, r.act[hit_idx]} -
                        4'h1;
          end
        end
      end
      absel_pkg::ACC_ACTIVE: begin
        if (r.acc_cnt == 4'h0) begin
          n.acc_st = absel_pkg::ACC_RESTORE;
          n.cs_n = 4'hF;
          n.acc_cnt = `ABSEL_RES_BASE + {2'h0, r.res[cs_idx]} -
                      4'h1;
        end else begin
          n.acc_cnt = r.acc_cnt - 4'h1;
        end
      end
      absel_pkg::ACC_RESTORE: begin
        if (r.acc_cnt == 4'h0) begin
          n.acc_st = absel_pkg::ACC_IDLE;
          n.acc_busy = 1'b0;
          n.acc_done = 1'b1;
        end else begin
          n.acc_cnt = r.acc_cnt - 4'h1;
        end
      end
      default: begin
        n.acc_st = absel_pkg::ACC_IDLE;
        n.cs_n = 4'hF;
        n.acc_busy = 1'b0;
      end
    endcase

    // dma acknowledge pulse shaper
    case (r.ack_st)
      absel_pkg::ACK_IDLE: begin
        if (ack_req_in) begin
          n.ack_st = absel_pkg::ACK_LOW;
          n.ack_busy = 1'b1;
          n.ack_n = 1'b0;
          n.ack_cnt = `ABSEL_ACK_LOW_BASE - 4'h1 +
                      (ack_is_tx_in ? {1'b0, r.tx_low}
                                    : {1'b0, r.rx_low});
          // remember which timing set for the high phase
          n.ack_done = 1'b0;
          n.ack_high_tx = ack_is_tx_in;
        end
      end
      absel_pkg::ACK_LOW: begin
        if (r.ack_cnt == 4'h0) begin
          n.ack_st = absel_pkg::ACK_HIGH;
          n.ack_n = 1'b1;
          n.ack_cnt = `ABSEL_ACK_HIGH_BASE - 4'h1 +
                      (r.ack_high_tx ? {2'h0, r.tx_high}
                                     : {2'h0, r.rx_high});
        end else begin
          n.ack_cnt = r.ack_cnt - 4'h1;
        end
      end
      absel_pkg::ACK_HIGH: begin
        if (r.ack_cnt == 4'h0) begin
          n.ack_st = absel_pkg::ACK_IDLE;
          n.ack_busy = 1'b0;
          n.ack_done = 1'b1;
        end else begin
          n.ack_cnt = r.ack_cnt - 4'h1;
        end
      end
      default: begin
        n.ack_st = absel_pkg::ACK_IDLE;
        n.ack_n = 1'b1;
        n.ack_busy = 1'b0;
      end
    endcase

    // aux reset follows the control bit once out of chip reset
    n.aux_rst = n.sw_rst;
    // enable kept as its own flop so the pin needs no inverter
    n.clk_en = ~n.clk_dis;

    if (!resetn_in) begin
      // timing fields have no defined reset; zero keeps sims clean
      n = '0;
      n.cs_n = 4'hF;
      n.ack_n = 1'b1;
      n.clk_dis = `ABSEL_CTRL_CLKDIS_RST;
      n.clk_en = ~`ABSEL_CTRL_CLKDIS_RST;
      n.sw_rst = `ABSEL_CTRL_RST_RST;
      n.aux_rst = 1'b1;
    end
  end

  always_ff @(posedge clock_in) begin
    r <= n;
  end

  assign reg_rdata_out = r.rdata;
  assign reg_rvalid_out = r.rvalid;
  assign acc_busy_out = r.acc_busy;
  assign acc_done_out = r.acc_done;
  assign acc_miss_out = r.acc_miss;
  assign cs_n_out = r.cs_n;
  assign ack_busy_out = r.ack_busy;
  assign ack_done_out = r.ack_done;
  assign dma_ack_n_out = r.ack_n;
  // gates a clock buffer outside; a flop cannot copy the clock itself
  assign aux_clk_enable_out = r.clk_en;
  assign aux_reset_out = r.aux_rst;

endmodule

/* File: dv/absel_monitor.sv */
`timescale 1ns/1ps
module absel_monitor (
  input wire logic clock_in, // bus clock
  input wire logic resetn_in, // chip reset
  input wire logic reg_rd_in, // read strobe
  input wire logic reg_rvalid_out, // read valid
  input wire logic acc_miss_out, // access refused
  input wire logic acc_done_out, // access done
  input wire logic [3:0] cs_n_out, // chip selects
  input wire logic dma_ack_n_out, // dma ack
  input wire logic aux_reset_out // aux reset
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!resetn_in);
  chk_cs_onehot: assert property ($onehot0(~cs_n_out))
    else $error("more than one chip select low");
  chk_cs_active: assert property ($fell(&cs_n_out) |-> !(&cs_n_out) [*3])
    else $error("chip select low too short");
  chk_cs_restore: assert property ($rose(&cs_n_out) |-> (&cs_n_out) [*2])
    else $error("restore time too short");
  chk_done_idle: assert property (acc_done_out |-> &cs_n_out)
    else $error("done while chip select low");
  chk_miss_nocs: assert property (acc_miss_out |-> &cs_n_out)
    else $error("chip select on refused access");
  chk_ack_low: assert property ($fell(dma_ack_n_out) |->
    !dma_ack_n_out [*2])
    else $error("dma ack low too short");
  chk_read_valid: assert property (reg_rd_in |=> reg_rvalid_out)
    else $error("read not answered");
  chk_rst_aux: assert property (disable iff (1'b0)
    !resetn_in |=> aux_reset_out)
    else $error("aux reset idle in chip reset");
  chk_rst_idle: assert property (disable iff (1'b0)
    !resetn_in |=> &cs_n_out && dma_ack_n_out)
    else $error("outputs active in chip reset");
endmodule
bind absel_top absel_monitor absel_monitor_inst (.clock_in, .resetn_in,
  .reg_rd_in, .reg_rvalid_out, .acc_miss_out, .acc_done_out, .cs_n_out,
  .dma_ack_n_out, .aux_reset_out);

/* File: dv/absel_periph_model.sv */
`timescale 1ns/1ps
module absel_periph_model (
  input wire logic clock_in, // bus clock
  input wire logic [3:0] cs_n_in, // chip selects
  input wire logic dma_ack_n_in, // dma ack
  output logic [3:0] cs_sel_out = 0, // last selected device
  output logic [3:0] cs_width_out = 0, // last select low span
  output logic [3:0] ack_width_out = 0 // last ack low span
);
  logic [3:0] cs_cnt = 0;
  logic [3:0] ack_cnt = 0;
  // slow device latches its strobe span; no data lines in this block
  always @(posedge clock_in) begin
    cs_cnt <= (cs_n_in != 4'hF) ? cs_cnt + 4'h1 : 4'h0;
    if (cs_n_in != 4'hF) begin
      cs_sel_out <= ~cs_n_in;
      cs_width_out <= cs_cnt + 4'h1;
    end
    ack_cnt <= dma_ack_n_in ? 4'h0 : ack_cnt + 4'h1;
    if (!dma_ack_n_in) begin
      ack_width_out <= ack_cnt + 4'h1;
    end
  end
endmodule

/* File: dv/absel_top_tb_top.sv */
`timescale 1ns/1ps
`include "absel_map.svh"
module absel_top_tb_top;
  logic clock_in = 0;
  logic resetn_in = 0;
  logic wr = 0;
  logic rd = 0;
  logic areq = 0;
  logic kreq = 0;
  logic ktx = 0;
  logic [15:0] addr = 0;
  logic [31:0] wdat = 0;
  logic [17:0] aaddr = 0;
  logic [31:0] rdat;
  logic rv, abusy, adone, amiss, kbusy, kdone, kn, clken, arst;
  logic [3:0] csn, sel, cs_w, ack_w;
  logic [31:0] cfg [4] = '{32'h1, 32'h47611, 32'h201000, 32'h302231};
  logic [17:0] ta [6] = '{0, 18'h7FFC, 18'h2000, 18'h20000, 18'h3FFFC, 1};
  int tix [6] = '{0, 1, -1, -1, 3, -1};
  int tlo [6] = '{3, 10, 0, 0, 5, 0};
  int thi [6] = '{2, 5, 0, 0, 3, 0};
  int n_mismatch = 0;
  int n_tests = 0;
  absel_top absel_top_inst (.clock_in, .resetn_in, .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_addr_in(addr), .reg_wdata_in(wdat),
    .reg_rdata_out(rdat), .reg_rvalid_out(rv), .acc_req_in(areq),
    .acc_addr_in(aaddr), .acc_busy_out(abusy), .acc_done_out(adone),
    .acc_miss_out(amiss), .cs_n_out(csn), .ack_req_in(kreq),
    .ack_is_tx_in(ktx), .ack_busy_out(kbusy), .ack_done_out(kdone),
    .dma_ack_n_out(kn), .aux_clk_enable_out(clken), .aux_reset_out(arst));
  absel_periph_model absel_periph_model_inst (.clock_in, .cs_n_in(csn),
    .dma_ack_n_in(kn), .cs_sel_out(sel), .cs_width_out(cs_w),
    .ack_width_out(ack_w));
  initial begin
    forever #12.5 clock_in = ~clock_in;
  end
  task automatic cmp(string nm, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wreg(logic [15:0] a, logic [31:0] d);
    @(posedge clock_in);
    wr <= 1;
    addr <= a;
    wdat <= d;
    @(posedge clock_in);
    wr <= 0;
  endtask
  task automatic rreg(logic [15:0] a, logic [31:0] e, logic [31:0] m);
    @(posedge clock_in);
    rd <= 1;
    addr <= a;
    @(posedge clock_in);
    rd <= 0;
    #1;
    cmp("rvalid", 1, rv);
    cmp("rdata", e, rdat & m);
  endtask
  // counts idle cycles while busy: the restore or ack high phase
  task automatic run(logic ack, logic tx, logic [17:0] a, output int n);
    n = 0;
    @(posedge clock_in);
    if (ack) kreq <= 1;
    else areq <= 1;
    ktx <= tx;
    aaddr <= a;
    @(posedge clock_in);
    kreq <= 0;
    areq <= 0;
    repeat (40) begin
      #1;
      if (amiss === 1'b1 || adone === 1'b1 || kdone === 1'b1) break;
      if (ack ? (kbusy === 1'b1 && kn === 1'b1)
              : (abusy === 1'b1 && csn === 4'hF)) n++;
      @(posedge clock_in);
    end
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    #100us;
    n_mismatch++;
    test_done();
  end
  initial begin
    int n;
    repeat (3) @(posedge clock_in);
    #1;
    cmp("aux reset", 1, arst);
    cmp("clk enable", 1, clken);
    @(posedge clock_in);
    resetn_in <= 1;
    for (int i = 0; i < 4; i++) begin
      rreg(`ABSEL_CSW0_OFS + 16'(4 * i), 0, 32'hFFC1_89CF);
    end
    rreg(`ABSEL_CTRL_OFS, 0, '1);
    for (int i = 0; i < 4; i++) begin
      wreg(`ABSEL_CSW0_OFS + 16'(4 * i), cfg[i]);
    end
    for (int i = 0; i < 4; i++) begin
      rreg(`ABSEL_CSW0_OFS + 16'(4 * i), cfg[i], '1);
    end
    rreg(16'hB010, 0, '1);
    $display("register test done");
    for (int i = 0; i < 6; i++) begin
      run(0, 0, ta[i], n);
      cmp("miss", tix[i] < 0, amiss);
      cmp("done", tix[i] >= 0, adone);
      if (tix[i] >= 0) begin
        cmp("cs sel", 1 << tix[i], sel);
        cmp("cs width", tlo[i], cs_w);
        cmp("restore", thi[i], n);
      end
    end
    $display("chip select test done");
    wreg(`ABSEL_RX_ACK_OFS, 32'h73);
    wreg(`ABSEL_TX_ACK_OFS, 32'h0);
    rreg(`ABSEL_RX_ACK_OFS, 32'h73, '1);
    run(1, 0, 0, n);
    cmp("rx ack low", 9, ack_w);
    cmp("rx ack high", 4, n);
    cmp("rx ack done", 1, kdone);
    run(1, 1, 0, n);
    cmp("tx ack low", 2, ack_w);
    cmp("tx ack high", 1, n);
    $display("ack test done");
    wreg(`ABSEL_CTRL_OFS, 32'h7);
    rreg(`ABSEL_CTRL_OFS, 32'h3, '1);
    cmp("aux reset", 1, arst);
    cmp("clk enable", 0, clken);
    wreg(`ABSEL_CTRL_OFS, 32'h0);
    #1;
    cmp("aux reset", 0, arst);
    cmp("clk enable", 1, clken);
    @(posedge clock_in);
    resetn_in <= 0;
    @(posedge clock_in);
    #1;
    cmp("aux reset", 1, arst);
    @(posedge clock_in);
    resetn_in <= 1;
    rreg(`ABSEL_CSW1_OFS, 0, 32'h1);
    $display("control test done");
    test_done();
  end
endmodule
